//--- include/hjt_params.svh
`ifndef HJT_PARAMS_SVH
`define HJT_PARAMS_SVH

`define HJT_AXES          3
`define HJT_WHEELS        2
`define HJT_PW            32
`define HJT_VW            16
`define HJT_MW            64
`define HJT_CLK_MHZ       20
`define HJT_IPO_US        1000
`define HJT_IPO_CYC       (`HJT_IPO_US * `HJT_CLK_MHZ)
`define HJT_IDLE_TICKS    8'h2
`define HJT_CNT_MAX       8'hff
`define HJT_INC_X1        32'h1
`define HJT_INC_X10       32'ha
`define HJT_INC_X100      32'h64
`define HJT_INC_X1000     32'h3e8
`define HJT_ALM_W         3
`define HJT_ALM_REJECT    0
`define HJT_ALM_SWLIM     1
`define HJT_ALM_HWLIM     2
`define HJT_AXB_WCS       7
`define HJT_AXB_NUM_W     7
`define HJT_TRANSVERSE_AX 0

`endif

//--- include/hjt_pkg.sv
`include "hjt_params.svh"

package hjt_pkg;

    typedef enum logic [2:0] {
        HJT_INC_NONE          = 3'h0,
        HJT_INCREMENT_X1      = 3'h1,
        HJT_INCREMENT_X10     = 3'h2,
        HJT_INCREMENT_X100    = 3'h3,
        HJT_INCREMENT_X1000   = 3'h4
    } hjt_inc_t;

    typedef enum logic [1:0] {
        HJT_MOT_STOP  = 2'h0,
        HJT_MOT_RUN   = 2'h1,
        HJT_MOT_BRAKE = 2'h2
    } hjt_mot_t;

endpackage

//--- include/hjt_wheel_if.sv
`timescale 1ns/1ps

interface hjt_wheel_if;
    import hjt_pkg::*;
    logic                      valid;
    logic signed [`HJT_PW-1:0] delta;
    logic [`HJT_AXES-1:0]      axis_hot;
    logic                      en;
    logic                      workpiece_coordinates;
    modport src (output valid, output delta, output axis_hot, output en, output workpiece_coordinates);
    modport dst (input valid, input delta, input axis_hot, input en, input workpiece_coordinates);
endinterface

//--- rtl/hjt_wheel.sv
`timescale 1ns/1ps

module hjt_wheel
    import hjt_pkg::*;
(
    input  wire logic                     ref_clk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     pulse_i,
    input  wire logic                     pulse_dir_i,
    input  wire logic                     wheel_en_i,
    input  wire logic [7:0]               axis_byte_i,
    input  wire logic                     accept_i,
    input  wire hjt_inc_t                 inc_sel_i,
    input  wire logic signed [15:0]       pulses_per_detent_i,
    hjt_wheel_if.src                      wo
);

    logic signed [`HJT_PW-1:0] inc_factor;
    logic signed [`HJT_PW-1:0] prod;
    logic [`HJT_AXES-1:0]      hot;

    always_comb begin
        case (inc_sel_i)
            HJT_INCREMENT_X1:    inc_factor = `HJT_INC_X1;
            HJT_INCREMENT_X10:   inc_factor = `HJT_INC_X10;
            HJT_INCREMENT_X100:  inc_factor = `HJT_INC_X100;
            HJT_INCREMENT_X1000: inc_factor = `HJT_INC_X1000;
            default:             inc_factor = '0;
        endcase
    end

    // signed detent weight flips the wheel sense when negative
    assign prod = inc_factor * `HJT_PW'(pulses_per_detent_i);

    // axis numbers run from 1; bit 7 picks the coordinate system
    for (genvar g = 0; g < `HJT_AXES; g++) begin : g_dec
        assign hot[g] = (axis_byte_i[`HJT_AXB_NUM_W-1:0] == `HJT_AXB_NUM_W'(g + 1));
    end

    // every strobe cycle is one pulse, none merged
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            wo.valid    <= 1'b0;
            wo.delta    <= '0;
            wo.axis_hot <= '0;
            wo.en       <= 1'b0;
            wo.workpiece_coordinates      <= 1'b0;
        end else begin
            wo.valid    <= pulse_i && accept_i && wheel_en_i && (|hot);
            wo.delta    <= pulse_dir_i ? -prod : prod;
            wo.axis_hot <= hot;
            wo.en       <= wheel_en_i;
            wo.workpiece_coordinates      <= axis_byte_i[`HJT_AXB_WCS];
        end
    end

endmodule

//--- rtl/hjt_traverse.sv
// Summary of operation
// - pulses taken only in jog mode with an increment selected.
// - axis moves plus or minus with wheel direction.
// - mode 1 pulses are path; mode 0 velocity, braking when idle.
// - distance is pulses x increment x detent weight x axis weight.
// - plus and minus traverse command bits, following motion direction.
// - pulses for an axis under key jog rejected with alarm.
// - at most two wheels, two axes moved at once.
// - axis byte per wheel; bit 7 picks machine or workpiece frame.
// - pulses counted up to the top pulse rate.
// - velocity clamped to axis limit, jog acceleration ramp.
// - reset or clear distance to go cancels motion and distance.
// - halt interrupts keeping distance; resume finishes it.
// - small reversal recomputes end point, braking first if needed.
// - threshold reversal brakes, pulses ignored until standstill.
// - motion stops at first active limit with alarm.
// - keep setting stores excess past limit; clear or deassign drops it.
// - discard setting drops pulses ending past the limit.
// - soft limits only when referenced; hard limits always.
// - brake to stop on soft limit; fast stop on hard limit.
// - at a limit, motion toward it blocked, away allowed.
// - leaving jog only when all axes in coarse exact stop.
// - transverse axis moves half distance per pulse.
// - reversal threshold default 2; zero blocks immediate reversal.
// - negative detent weight inverts direction.
`timescale 1ns/1ps

module hjt_traverse
    import hjt_pkg::*;
#(
    parameter int unsigned IPO_CYCLES = `HJT_IPO_CYC
)(
    input  wire logic                                  ref_clk_i,
    input  wire logic                                  sys_rst_i,
    input  wire logic                                  manual_jog_mode_i,
    input  wire logic [2:0]                            inc_sel_i,
    input  wire logic                                  handwheel_travel_mode_select_i,
    input  wire logic [7:0]                            reversal_pulse_threshold_i,
    input  wire logic                                  limit_keep_fictive_i,
    input  wire logic [`HJT_WHEELS-1:0]                wheel_pulse_i,
    input  wire logic [`HJT_WHEELS-1:0]                wheel_dir_i,
    input  wire logic [`HJT_WHEELS-1:0]                wheel_en_i,
    input  wire logic [`HJT_WHEELS-1:0][7:0]           wheel_axis_byte_i,
    input  wire logic [`HJT_WHEELS-1:0][15:0]          pulses_per_detent_i,
    input  wire logic [`HJT_AXES-1:0][15:0]            increment_path_weight_i,
    input  wire logic [`HJT_AXES-1:0][`HJT_VW-2:0]     axis_velocity_limit_i,
    input  wire logic [`HJT_AXES-1:0][`HJT_VW-2:0]     jog_accel_i,
    input  wire logic [`HJT_AXES-1:0]                  key_jog_active_i,
    input  wire logic [`HJT_AXES-1:0]                  clear_dtg_i,
    input  wire logic [`HJT_AXES-1:0]                  referenced_i,
    input  wire logic [`HJT_AXES-1:0][`HJT_PW-1:0]     sw_limit_plus_i,
    input  wire logic [`HJT_AXES-1:0][`HJT_PW-1:0]     sw_limit_minus_i,
    input  wire logic [`HJT_AXES-1:0]                  hw_limit_plus_i,
    input  wire logic [`HJT_AXES-1:0]                  hw_limit_minus_i,
    input  wire logic [`HJT_AXES-1:0]                  exact_stop_coarse_i,
    input  wire logic [`HJT_AXES-1:0][`HJT_ALM_W-1:0]  alarm_clear_i,
    input  wire logic                                  nc_stop_i,
    input  wire logic                                  nc_start_i,
    input  wire logic                                  mode_change_req_i,
    output logic [`HJT_AXES-1:0][`HJT_PW-1:0]          setpoint_o,
    output logic [`HJT_AXES-1:0][`HJT_VW-1:0]          velocity_o,
    output logic [`HJT_AXES-1:0]                       trav_cmd_plus_o,
    output logic [`HJT_AXES-1:0]                       trav_cmd_minus_o,
    output logic [`HJT_AXES-1:0]                       wcs_assigned_o,
    output logic [`HJT_AXES-1:0][`HJT_ALM_W-1:0]       alarm_o,
    output logic                                       halted_o,
    output logic                                       mode_change_ok_o
);

    logic                                   accept;
    logic                                   tick;
    logic [31:0]                            ipo_cnt;
    logic [`HJT_WHEELS-1:0]                 w_valid;
    logic [`HJT_WHEELS-1:0]                 w_en;
    logic [`HJT_WHEELS-1:0]                 w_wcs;
    logic [`HJT_WHEELS-1:0][`HJT_PW-1:0]    w_delta;
    logic [`HJT_WHEELS-1:0][`HJT_AXES-1:0]  w_hot;

    assign accept = manual_jog_mode_i && (hjt_inc_t'(inc_sel_i) != HJT_INC_NONE);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ipo_cnt <= '0;
            tick    <= 1'b0;
        end else if (ipo_cnt == 32'(IPO_CYCLES - 1)) begin
            ipo_cnt <= '0;
            tick    <= 1'b1;
        end else begin
            ipo_cnt <= ipo_cnt + 32'h1;
            tick    <= 1'b0;
        end
    end

    // stop wins over start when both arrive together
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            halted_o <= 1'b0;
        end else if (nc_stop_i) begin
            halted_o <= 1'b1;
        end else if (nc_start_i) begin
            halted_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mode_change_ok_o <= 1'b0;
        end else begin
            mode_change_ok_o <= mode_change_req_i && (&exact_stop_coarse_i);
        end
    end

    for (genvar w = 0; w < `HJT_WHEELS; w++) begin : g_wheel
        hjt_wheel_if wif ();

        hjt_wheel u_wheel (
            .ref_clk_i           (ref_clk_i),
            .sys_rst_i           (sys_rst_i),
            .pulse_i             (wheel_pulse_i[w]),
            .pulse_dir_i         (wheel_dir_i[w]),
            .wheel_en_i          (wheel_en_i[w]),
            .axis_byte_i         (wheel_axis_byte_i[w]),
            .accept_i            (accept),
            .inc_sel_i           (hjt_inc_t'(inc_sel_i)),
            .pulses_per_detent_i (pulses_per_detent_i[w]),
            .wo                  (wif.src)
        );

        assign w_valid[w] = wif.valid;
        assign w_delta[w] = wif.delta;
        assign w_hot[w]   = wif.axis_hot;
        assign w_en[w]    = wif.en;
        assign w_wcs[w]   = wif.workpiece_coordinates;
    end

    for (genvar a = 0; a < `HJT_AXES; a++) begin : g_axis
        logic signed [`HJT_PW-1:0] pos, dtg, excess, next_dtg, next_exc, d_sum, wd, wd_eff;
        logic signed [`HJT_PW-1:0] tot, pos_b, dtg_b, end_pt, lim_p, lim_m;
        logic signed [`HJT_VW-1:0] v, next_v;
        logic signed [`HJT_MW-1:0] s, ns, sa, vl, dm, vs;
        hjt_mot_t                  st, next_st;
        logic [7:0]                rev_cnt, idle_cnt;
        logic                      hit, assigned, wcs_hit, rev, rej, go_brake, vel_stop, acc;
        logic                      keep_exc, over_p, over_m, hw_blk, hw_run, sw_hit, hw_hit;

        assign lim_p  = sw_limit_plus_i[a];
        assign lim_m  = sw_limit_minus_i[a];
        assign sa     = `HJT_MW'(jog_accel_i[a]);
        assign vl     = `HJT_MW'(axis_velocity_limit_i[a]);
        assign vs     = `HJT_MW'(v);
        assign hw_run = (hw_limit_plus_i[a] && v > 0) || (hw_limit_minus_i[a] && v < 0);

        always_comb begin
            d_sum    = '0;
            hit      = 1'b0;
            assigned = 1'b0;
            wcs_hit  = 1'b0;
            for (int w = 0; w < `HJT_WHEELS; w++) begin
                if (w_en[w] && w_hot[w][a]) begin
                    assigned = 1'b1;
                    wcs_hit  = wcs_hit | w_wcs[w];
                end
                if (w_valid[w] && w_hot[w][a]) begin
                    hit   = 1'b1;
                    d_sum = d_sum + w_delta[w];
                end
            end
            wd = d_sum * $signed({1'b0, increment_path_weight_i[a]});
            if (a == `HJT_TRANSVERSE_AX) begin
                wd = wd >>> 1;
            end
            pos_b = tick ? pos + `HJT_PW'(v) : pos;
            dtg_b = tick ? dtg - `HJT_PW'(v) : dtg;
            rev = hit && (v != 0) && (wd != 0) && ((wd < 0) != (v < 0));
            rej = hit && key_jog_active_i[a];
            go_brake = hit && !rej && rev && (st == HJT_MOT_RUN)
                && (reversal_pulse_threshold_i != 8'h0)
                && (rev_cnt + 8'h1 >= reversal_pulse_threshold_i);
            vel_stop = !handwheel_travel_mode_select_i && (st == HJT_MOT_RUN)
                && (idle_cnt >= `HJT_IDLE_TICKS);
            acc = hit && !rej && (st != HJT_MOT_BRAKE) && !go_brake
                && !(rev && reversal_pulse_threshold_i == 8'h0);
            tot      = excess + wd;
            keep_exc = (excess != 0) && (tot != 0) && ((tot < 0) == (excess < 0));
            wd_eff   = (excess != 0) ? tot : wd;
            end_pt   = pos_b + dtg_b + wd_eff;
            over_p   = referenced_i[a] && (end_pt > lim_p);
            over_m   = referenced_i[a] && (end_pt < lim_m);
            hw_blk   = (hw_limit_plus_i[a] && wd_eff > 0)
                || (hw_limit_minus_i[a] && wd_eff < 0);
            next_dtg = dtg_b;
            next_exc = excess;
            sw_hit   = 1'b0;
            hw_hit   = hw_run;
            if (clear_dtg_i[a]) begin
                next_dtg = '0;
                next_exc = '0;
            end else if (go_brake || vel_stop || st == HJT_MOT_BRAKE) begin
                next_dtg = '0;
            end else if (hw_run) begin
                next_dtg = '0;
            end else if (acc) begin
                if (keep_exc) begin
                    next_exc = tot;
                end else if (hw_blk) begin
                    hw_hit = 1'b1;
                end else if (over_p || over_m) begin
                    sw_hit = 1'b1;
                    if (limit_keep_fictive_i) begin
                        next_dtg = (over_p ? lim_p : lim_m) - pos_b;
                        next_exc = end_pt - (over_p ? lim_p : lim_m);
                    end
                end else begin
                    next_dtg = dtg_b + wd_eff;
                    next_exc = '0;
                end
            end
            if (!assigned) begin
                next_exc = '0;
            end
        end

        // velocity profile, evaluated per interpolation tick
        always_comb begin
            dm = `HJT_MW'(dtg_b);
            if (dm < 0) begin
                dm = -dm;
            end
            s  = (dtg_b < 0) ? -vs : vs;
            ns = '0;
            if (vs > sa) begin
                ns = vs - sa;
            end else if (vs < -sa) begin
                ns = vs + sa;
            end
            next_v = v;
            if (tick) begin
                case (st)
                    HJT_MOT_STOP: begin
                        next_v = '0;
                    end
                    HJT_MOT_BRAKE: begin
                        next_v = `HJT_VW'(ns);
                    end
                    default: begin
                        if (hw_run) begin
                            next_v = '0;
                        end else if (halted_o || dtg_b == 0) begin
                            next_v = `HJT_VW'(ns);
                        end else begin
                            if (s < 0) begin
                                ns = s + sa;
                            end else if (s * (s + sa) >= ((sa * dm) <<< 1)) begin
                                ns = s - sa;
                            end else begin
                                ns = s + sa;
                            end
                            if (ns > vl) begin
                                ns = vl;
                            end
                            if (ns > dm) begin
                                ns = dm;
                            end
                            // never stall short of the end point
                            if (ns < 1 && s >= 0) begin
                                ns = `HJT_MW'(1);
                            end
                            next_v = `HJT_VW'((dtg_b < 0) ? -ns : ns);
                        end
                    end
                endcase
            end
        end

        always_comb begin
            next_st = st;
            case (st)
                HJT_MOT_STOP: begin
                    if (next_dtg != 0 && !halted_o) begin
                        next_st = HJT_MOT_RUN;
                    end
                end
                HJT_MOT_RUN: begin
                    if (go_brake || vel_stop) begin
                        next_st = HJT_MOT_BRAKE;
                    end else if (clear_dtg_i[a]) begin
                        next_st = HJT_MOT_STOP;
                    end else if (tick && next_v == 0 && dtg_b == 0) begin
                        next_st = HJT_MOT_STOP;
                    end
                end
                HJT_MOT_BRAKE: begin
                    if (v == 0 && next_v == 0) begin
                        next_st = HJT_MOT_STOP;
                    end
                end
                default: begin
                    next_st = HJT_MOT_STOP;
                end
            endcase
        end

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                st <= HJT_MOT_STOP;
            end else begin
                st <= next_st;
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                dtg    <= '0;
                excess <= '0;
            end else begin
                dtg    <= next_dtg;
                excess <= next_exc;
            end
        end

        // clear drops the setpoint motion at once, the position stays
        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                pos <= '0;
                v   <= '0;
            end else begin
                pos <= pos_b;
                v   <= clear_dtg_i[a] ? '0 : next_v;
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i || st != HJT_MOT_RUN || (hit && !rev)) begin
                rev_cnt <= '0;
            end else if (hit && rev && rev_cnt != `HJT_CNT_MAX) begin
                rev_cnt <= rev_cnt + 8'h1;
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i || hit || st != HJT_MOT_RUN) begin
                idle_cnt <= '0;
            end else if (tick && idle_cnt != `HJT_CNT_MAX) begin
                idle_cnt <= idle_cnt + 8'h1;
            end
        end

        // event set wins over a simultaneous clear
        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                alarm_o[a] <= '0;
            end else begin
                alarm_o[a] <= (alarm_o[a] & ~alarm_clear_i[a]) | {hw_hit, sw_hit, rej};
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (sys_rst_i) begin
                setpoint_o[a]       <= '0;
                velocity_o[a]       <= '0;
                trav_cmd_plus_o[a]  <= 1'b0;
                trav_cmd_minus_o[a] <= 1'b0;
                wcs_assigned_o[a]   <= 1'b0;
            end else begin
                setpoint_o[a]       <= pos_b;
                velocity_o[a]       <= clear_dtg_i[a] ? '0 : next_v;
                trav_cmd_plus_o[a]  <= !clear_dtg_i[a] && (next_v > 0);
                trav_cmd_minus_o[a] <= !clear_dtg_i[a] && (next_v < 0);
                wcs_assigned_o[a]   <= wcs_hit;
            end
        end
    end

endmodule

//--- bench/hjt_wheel_gen.sv
`timescale 1ns/1ps
module hjt_wheel_gen #(
    parameter int GAP = 200
)(
    input  wire logic       ref_clk_i,
    input  wire logic       go_i,
    input  wire logic       neg_i,
    input  wire logic [7:0] count_i,
    output logic            pulse_o = 1'b0,
    output logic            dir_o = 1'b0,
    output logic            busy_o
);
    int         gap = 0;
    logic [7:0] left = 8'h0;
    assign busy_o = left != 8'h0 || gap != 0;
    // one strobe per GAP cycles keeps the wheel at its top pulse rate
    always @(posedge ref_clk_i) begin
        pulse_o <= 1'b0;
        if (go_i) begin
            left <= count_i;
            dir_o <= neg_i;
        end else if (left != 8'h0 && gap == 0) begin
            pulse_o <= 1'b1;
            left <= left - 8'h1;
            gap <= GAP - 1;
        end else if (gap != 0) begin
            gap <= gap - 1;
        end
    end
endmodule

//--- bench/hjt_traverse_asserts.sv
`timescale 1ns/1ps
module hjt_traverse_asserts
    import hjt_pkg::*;
#(
    parameter int unsigned IPO_CYCLES = 8
)(
    input wire logic             ref_clk_i,
    input wire logic             sys_rst_i,
    input wire logic             manual_jog_mode_i,
    input wire logic [2:0]       inc_sel_i,
    input wire logic [1:0]       wheel_pulse_i,
    input wire logic [1:0]       wheel_en_i,
    input wire logic [1:0][7:0]  wheel_axis_byte_i,
    input wire logic [2:0]       key_jog_active_i,
    input wire logic [2:0]       clear_dtg_i,
    input wire logic [2:0][2:0]  alarm_clear_i,
    input wire logic             nc_stop_i,
    input wire logic             mode_change_req_i,
    input wire logic [2:0]       exact_stop_coarse_i,
    input wire logic [2:0][31:0] setpoint_o,
    input wire logic [2:0][15:0] velocity_o,
    input wire logic [2:0]       trav_cmd_plus_o,
    input wire logic [2:0]       trav_cmd_minus_o,
    input wire logic [2:0]       wcs_assigned_o,
    input wire logic [2:0][2:0]  alarm_o,
    input wire logic             halted_o,
    input wire logic             mode_change_ok_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_one_cmd; (trav_cmd_plus_o & trav_cmd_minus_o) == 3'h0; endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("both command bits");
    property p_plus; $signed(velocity_o[1]) > 0 |-> trav_cmd_plus_o[1]; endproperty
    a_plus: assert property (p_plus) else $error("plus bit missing");
    property p_down;
        $signed(setpoint_o[1]) < $signed($past(setpoint_o[1])) |-> $past(trav_cmd_minus_o[1]);
    endproperty
    a_down: assert property (p_down) else $error("minus bit missing");
    property p_mode; !$past(sys_rst_i) |-> mode_change_ok_o ==
        ($past(mode_change_req_i) && &$past(exact_stop_coarse_i)); endproperty
    a_mode: assert property (p_mode) else $error("mode change grant wrong");
    property p_halt; nc_stop_i |=> halted_o; endproperty
    a_halt: assert property (p_halt) else $error("halt not latched");
    property p_clear; clear_dtg_i[1] |-> ##2 velocity_o[1] == 16'h0; endproperty
    a_clear: assert property (p_clear) else $error("clear left motion");
    property p_reject; wheel_pulse_i[0] && wheel_en_i[0] && manual_jog_mode_i &&
        inc_sel_i == 3'h2 && wheel_axis_byte_i[0] == 8'h02 && key_jog_active_i[1]
        |-> ##[1:3] alarm_o[1][0]; endproperty
    a_reject: assert property (p_reject) else $error("no reject alarm");
    property p_sticky; alarm_o[1][0] && !alarm_clear_i[1][0] |=> alarm_o[1][0]; endproperty
    a_sticky: assert property (p_sticky) else $error("alarm dropped");
    property p_wcs; wheel_en_i[0] && wheel_axis_byte_i[0] == 8'h81 &&
        $stable(wheel_axis_byte_i[0]) |-> ##[1:2] wcs_assigned_o[0]; endproperty
    a_wcs: assert property (p_wcs) else $error("workpiece flag missing");
    c_minus: cover property (trav_cmd_minus_o[1]);
    c_hw: cover property (alarm_o[0][2]);
    c_halt: cover property (halted_o);
    c_mode: cover property (mode_change_ok_o);
endmodule
bind hjt_traverse hjt_traverse_asserts #(.IPO_CYCLES(IPO_CYCLES)) chk_u (.*);

//--- bench/handwheel_jog_traverse_tb_top.sv
`timescale 1ns/1ps
module handwheel_jog_traverse_tb_top;
    import hjt_pkg::*;
    logic ref_clk_i = 0, sys_rst_i = 1, manual_jog_mode_i = 1, nc_stop_i = 0, nc_start_i = 0;
    logic handwheel_travel_mode_select_i = 1, limit_keep_fictive_i = 0, mode_change_req_i = 0;
    logic [2:0] inc_sel_i = 3'h2, key_jog_active_i = 3'h0, clear_dtg_i = 3'h0;
    logic [2:0] referenced_i = 3'h0, hw_limit_plus_i = 3'h0, hw_limit_minus_i = 3'h0;
    logic [2:0] exact_stop_coarse_i = 3'h0, trav_cmd_plus_o, trav_cmd_minus_o, wcs_assigned_o;
    logic [7:0] reversal_pulse_threshold_i = 8'h2, gen_n = 8'h0;
    logic [1:0] wheel_en_i = 2'h1;
    logic [1:0][7:0] wheel_axis_byte_i = 16'h0002;
    logic [1:0][15:0] pulses_per_detent_i = 32'h00010001;
    logic [2:0][15:0] increment_path_weight_i = 48'h000100010001, velocity_o;
    logic [2:0][14:0] axis_velocity_limit_i = {3{15'h3fff}}, jog_accel_i = {3{15'h3fff}};
    logic [2:0][31:0] sw_limit_plus_i = '0, sw_limit_minus_i = '0, setpoint_o;
    logic [2:0][2:0] alarm_clear_i = '0, alarm_o;
    logic halted_o, mode_change_ok_o, gen_pulse, gen_dir, gen_busy, gen_go = 0, gen_neg = 0;
    logic [31:0] pos1 = 32'h0;
    wire [1:0] wheel_pulse_i = {1'b0, gen_pulse};
    wire [1:0] wheel_dir_i = {1'b0, gen_dir};
    int fails = 0, tests_run = 0;
    hjt_traverse #(.IPO_CYCLES(8)) dut_u (.*);
    hjt_wheel_gen gen_u (.ref_clk_i(ref_clk_i), .go_i(gen_go), .neg_i(gen_neg),
        .count_i(gen_n), .pulse_o(gen_pulse), .dir_o(gen_dir), .busy_o(gen_busy));
    initial forever #25 ref_clk_i = ~ref_clk_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic turn(input logic [7:0] n, input logic neg);
        gen_n <= n;
        gen_neg <= neg;
        gen_go <= 1'b1;
        @(posedge ref_clk_i);
        gen_go <= 1'b0;
        for (int i = 0; i < 4000 && (gen_busy || i < 40); i++) @(posedge ref_clk_i);
    endtask
    task automatic hold(input logic stop);
        if (stop) nc_stop_i <= 1'b1;
        else nc_start_i <= 1'b1;
        @(posedge ref_clk_i);
        nc_stop_i <= 1'b0;
        nc_start_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask
    task automatic t_incs();
        for (int s = 1; s <= 4; s++) begin
            inc_sel_i <= s[2:0];
            turn(8'h1, 1'b0);
            pos1 = pos1 + 32'(10 ** (s - 1));
            check(setpoint_o[1], pos1);
        end
        inc_sel_i <= 3'h2;
        turn(8'h3, 1'b0);
        check(setpoint_o[1], pos1 + 32'd30);
        turn(8'h2, 1'b1);
        check(setpoint_o[1], pos1 + 32'd10);
        pulses_per_detent_i[0] <= 16'hffff;
        turn(8'h1, 1'b0);
        pulses_per_detent_i[0] <= 16'h1;
        check(setpoint_o[1], pos1);
    endtask
    task automatic t_refused();
        manual_jog_mode_i <= 1'b0;
        turn(8'h1, 1'b0);
        manual_jog_mode_i <= 1'b1;
        inc_sel_i <= 3'h0;
        turn(8'h1, 1'b0);
        inc_sel_i <= 3'h2;
        key_jog_active_i <= 3'h2;
        turn(8'h1, 1'b0);
        check(setpoint_o[1], pos1);
        check(alarm_o[1], 32'h1);
        key_jog_active_i <= 3'h0;
        alarm_clear_i[1] <= 3'h1;
        hold(1'b1);
        alarm_clear_i[1] <= 3'h0;
        hold(1'b0);
        check(alarm_o[1], 32'h0);
    endtask
    task automatic t_limit();
        wheel_axis_byte_i[0] <= 8'h81;
        hw_limit_plus_i <= 3'h1;
        turn(8'h1, 1'b0);
        check(setpoint_o[0], 32'h0);
        check(alarm_o[0], 32'h4);
        check(wcs_assigned_o, 32'h1);
        turn(8'h1, 1'b1);
        check(setpoint_o[0], 32'hfffffffb);
        hw_limit_plus_i <= 3'h0;
        wheel_axis_byte_i[0] <= 8'h02;
    endtask
    task automatic t_halt();
        hold(1'b1);
        turn(8'h2, 1'b0);
        check(halted_o, 32'h1);
        check(setpoint_o[1], pos1);
        hold(1'b0);
        turn(8'h0, 1'b0);
        pos1 = pos1 + 32'd20;
        check(setpoint_o[1], pos1);
        hold(1'b1);
        turn(8'h2, 1'b0);
        clear_dtg_i <= 3'h2;
        hold(1'b0);
        clear_dtg_i <= 3'h0;
        turn(8'h0, 1'b0);
        check(setpoint_o[1], pos1);
    endtask
    task automatic t_mode();
        mode_change_req_i <= 1'b1;
        exact_stop_coarse_i <= 3'h3;
        repeat (3) @(posedge ref_clk_i);
        check(mode_change_ok_o, 32'h0);
        exact_stop_coarse_i <= 3'h7;
        repeat (3) @(posedge ref_clk_i);
        check(mode_change_ok_o, 32'h1);
        mode_change_req_i <= 1'b0;
    endtask
    task automatic complete_run();
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        fails++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_incs();
        t_refused();
        t_limit();
        t_halt();
        t_mode();
        complete_run();
    end
endmodule
